//--- common/edge_digitizer_pkg.sv
// Constants shared by the reply video edge digitizer.
// Assumes one processing clock; no software-visible registers.
package edge_digitizer_pkg;
    // Bit positions of the pin inputs inside the synchroniser word
    localparam int PIN_SUM = 0;
    localparam int PIN_RISE = 1;
    localparam int PIN_FALL = 2;
    localparam int PIN_BEAM = 3;
    localparam int PIN_GATE = 4;
    localparam int PIN_COUNT = 5;
    // Input history: age 0 is t2+2, age 2 is t2, age 3 is t2-1
    localparam int HIST_DEPTH = 4;
    localparam int AGE_AHEAD2 = 0;
    localparam int AGE_AHEAD1 = 1;
    localparam int AGE_NOW = 2;
    localparam int AGE_BEFORE = 3;
    // Reply decoders cleared by the range gate opening pulse
    localparam int DECODER_COUNT = 4;
    // Beam flag delays in processing clocks, real and inferred front marks
    localparam int REAL_MARK_DELAY = 3;
    localparam int INFERRED_MARK_DELAY = 8;
    localparam int BEAM_LINE_DEPTH = 16;
    // Reset values
    localparam logic RESET_LOW = 1'b0;
    localparam logic [PIN_COUNT-1:0] SYNC_RESET = 5'h00;
    localparam logic [HIST_DEPTH-1:0] HIST_RESET = 4'h0;
endpackage

//--- hw/reply_video_edge_digitizer.sv
// Reply video edge digitizer: front/back edge marks, pulse-body window,
// initialization pulses and aligned beam flag.
// Assumes asynchronous quantizer pins and an inferred-front flag from
// logic on the same processing clock.
`timescale 1ns/1ps

// Function
// - Front mark on rising-slope fall with video
// - Front mark lasts one clock
// - Front mark starts window, goes downstream
// - Window high from front to back mark
// - Back unit enabled only during window
// - Back edge: video low, or short falling slope
// - Back edge: long falling slope lookahead cases
// - Back mark ends window, goes downstream
// - Range gate enables front, makes clear pulses
// - Gate open clears decoders, clear pulse clears buffer
// - No mainbeam during pulse means sidelobe
// - Beam flag delayed on real, inferred paths
// - Selector picks inferred path on flag
// - Everything on the processing clock
module reply_video_edge_digitizer #(
    parameter int REAL_DELAY = edge_digitizer_pkg::REAL_MARK_DELAY,
    parameter int INFERRED_DELAY = edge_digitizer_pkg::INFERRED_MARK_DELAY,
    parameter int DECODERS = edge_digitizer_pkg::DECODER_COUNT
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Quantizer pins
    input wire logic sum_video_in,
    input wire logic rising_slope_in,
    input wire logic falling_slope_in,
    input wire logic mainbeam_flag_in,
    input wire logic range_gate_in,
    // From the inferred-edge generator
    input wire logic inferred_front_flag_in,
    // Edge marks and window
    output logic found_front_mark_out,
    output logic found_back_mark_out,
    output logic pulse_body_window_out,
    output logic sidelobe_pulse_out,
    // Initialization pulses
    output logic [DECODERS-1:0] decoder_clear_out,
    output logic buffer_clear_pulse_out,
    // Beam flag toward the memory delay
    output logic aligned_beam_flag_out
);

    localparam int LINE = edge_digitizer_pkg::BEAM_LINE_DEPTH;

    initial begin
        if (REAL_DELAY < 1 || REAL_DELAY > LINE || INFERRED_DELAY < 1 ||
            INFERRED_DELAY > LINE || DECODERS < 1) begin
            $error("reply_video_edge_digitizer: unsupported parameters");
        end
    end

    logic [edge_digitizer_pkg::PIN_COUNT-1:0] meta_r;
    logic [edge_digitizer_pkg::PIN_COUNT-1:0] sync_r;
    logic [edge_digitizer_pkg::HIST_DEPTH-1:0] sum_h_r;
    logic [edge_digitizer_pkg::HIST_DEPTH-1:0] rise_h_r;
    logic [edge_digitizer_pkg::HIST_DEPTH-1:0] fall_h_r;
    logic [edge_digitizer_pkg::HIST_DEPTH-1:0] beam_h_r;
    logic gate_d_r;
    logic gate_on;
    logic gate_rise;
    logic front_nxt;
    logic back_case_a;
    logic back_case_b;
    logic back_case_long;
    logic back_nxt;
    logic [LINE-1:0] beam_line_r;
    logic beam_sel_nxt;

    // Pins pass two flops before anything reads them
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            meta_r <= edge_digitizer_pkg::SYNC_RESET;
            sync_r <= edge_digitizer_pkg::SYNC_RESET;
        end else begin
            meta_r <= {range_gate_in, mainbeam_flag_in, falling_slope_in,
                       rising_slope_in, sum_video_in};
            sync_r <= meta_r;
        end
    end

    // Short history so the back-edge test can look two clocks past t2.
    // Front marks are taken at the same age so window and back unit agree.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sum_h_r <= edge_digitizer_pkg::HIST_RESET;
            rise_h_r <= edge_digitizer_pkg::HIST_RESET;
            fall_h_r <= edge_digitizer_pkg::HIST_RESET;
            beam_h_r <= edge_digitizer_pkg::HIST_RESET;
        end else begin
            sum_h_r <= {sum_h_r[2:0], sync_r[edge_digitizer_pkg::PIN_SUM]};
            rise_h_r <= {rise_h_r[2:0], sync_r[edge_digitizer_pkg::PIN_RISE]};
            fall_h_r <= {fall_h_r[2:0], sync_r[edge_digitizer_pkg::PIN_FALL]};
            beam_h_r <= {beam_h_r[2:0], sync_r[edge_digitizer_pkg::PIN_BEAM]};
        end
    end

    assign gate_on = sync_r[edge_digitizer_pkg::PIN_GATE];
    assign gate_rise = gate_on & ~gate_d_r;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            gate_d_r <= edge_digitizer_pkg::RESET_LOW;
        end else begin
            gate_d_r <= gate_on;
        end
    end

    // Front mark: rising slope just ended with sum video present
    always_comb begin
        front_nxt = gate_on
            & rise_h_r[edge_digitizer_pkg::AGE_BEFORE]
            & ~rise_h_r[edge_digitizer_pkg::AGE_NOW]
            & sum_h_r[edge_digitizer_pkg::AGE_NOW];
    end

    // Back edge tests, all relative to t2 = AGE_NOW
    always_comb begin
        back_case_a = ~sum_h_r[edge_digitizer_pkg::AGE_NOW];
        back_case_b = ~fall_h_r[edge_digitizer_pkg::AGE_BEFORE]
            & fall_h_r[edge_digitizer_pkg::AGE_NOW]
            & ~sum_h_r[edge_digitizer_pkg::AGE_AHEAD1];
        back_case_long = ~fall_h_r[edge_digitizer_pkg::AGE_BEFORE]
            & fall_h_r[edge_digitizer_pkg::AGE_NOW]
            & fall_h_r[edge_digitizer_pkg::AGE_AHEAD1]
            & (~sum_h_r[edge_digitizer_pkg::AGE_AHEAD2]
               | fall_h_r[edge_digitizer_pkg::AGE_AHEAD2]
               | rise_h_r[edge_digitizer_pkg::AGE_AHEAD2]);
        back_nxt = pulse_body_window_out
            & (back_case_a | back_case_b | back_case_long);
    end

    // One-clock marks; a slope edge cannot repeat on the next clock
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            found_front_mark_out <= edge_digitizer_pkg::RESET_LOW;
            found_back_mark_out <= edge_digitizer_pkg::RESET_LOW;
        end else begin
            found_front_mark_out <= front_nxt;
            found_back_mark_out <= back_nxt;
        end
    end

    // Window rises with the front mark and falls with the back mark.
    // A new front mark on the same clock as a back edge starts a new body.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pulse_body_window_out <= edge_digitizer_pkg::RESET_LOW;
        end else if (front_nxt) begin
            pulse_body_window_out <= 1'b1;
        end else if (back_nxt) begin
            pulse_body_window_out <= 1'b0;
        end
    end

    // Sidelobe: sum pulse present with no mainbeam indication
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sidelobe_pulse_out <= edge_digitizer_pkg::RESET_LOW;
        end else begin
            sidelobe_pulse_out <= sum_h_r[edge_digitizer_pkg::AGE_NOW]
                & ~beam_h_r[edge_digitizer_pkg::AGE_NOW];
        end
    end

    // Initialization pulses on the opening edge of the range gate
    generate
        for (genvar d = 0; d < DECODERS; d++) begin : g_dec_clear
            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    decoder_clear_out[d] <= edge_digitizer_pkg::RESET_LOW;
                end else begin
                    decoder_clear_out[d] <= gate_rise;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            buffer_clear_pulse_out <= edge_digitizer_pkg::RESET_LOW;
        end else begin
            buffer_clear_pulse_out <= gate_rise;
        end
    end

    // Beam flag delay line with two taps; one line keeps both paths in step
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            beam_line_r <= '0;
        end else begin
            beam_line_r <= {beam_line_r[LINE-2:0],
                            beam_h_r[edge_digitizer_pkg::AGE_NOW]};
        end
    end

    always_comb begin
        if (inferred_front_flag_in) begin
            beam_sel_nxt = beam_line_r[INFERRED_DELAY-1];
        end else begin
            beam_sel_nxt = beam_line_r[REAL_DELAY-1];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            aligned_beam_flag_out <= edge_digitizer_pkg::RESET_LOW;
        end else begin
            aligned_beam_flag_out <= beam_sel_nxt;
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence seq_gate_open;
        !gate_d_r ##0 gate_on;
    endsequence

    // Short back-edge cases read straight from the history, not from the decode
    sequence seq_back_due;
        pulse_body_window_out
        && (!sum_h_r[edge_digitizer_pkg::AGE_NOW]
            || (!fall_h_r[edge_digitizer_pkg::AGE_BEFORE]
                && fall_h_r[edge_digitizer_pkg::AGE_NOW]
                && !sum_h_r[edge_digitizer_pkg::AGE_AHEAD1]));
    endsequence

    AST_FRONT_FIRES: assert property (
        $fell(rise_h_r[edge_digitizer_pkg::AGE_NOW])
        && sum_h_r[edge_digitizer_pkg::AGE_NOW] && gate_on
        |=> found_front_mark_out)
        else $error("front mark missing after slope end");

    AST_FRONT_ONE_CLOCK: assert property (
        found_front_mark_out |=> !found_front_mark_out)
        else $error("front mark longer than one clock");

    AST_WINDOW_STARTS: assert property (
        found_front_mark_out |-> pulse_body_window_out)
        else $error("front mark did not open window");

    AST_WINDOW_HOLDS: assert property (
        pulse_body_window_out && !back_nxt |=> pulse_body_window_out)
        else $error("window dropped without back mark");

    AST_WINDOW_ENDS: assert property (
        $fell(pulse_body_window_out) |-> found_back_mark_out)
        else $error("window fell without back mark");

    AST_BACK_ONLY_IN_WINDOW: assert property (
        found_back_mark_out |-> $past(pulse_body_window_out))
        else $error("back mark outside window");

    AST_BACK_FIRES: assert property (
        seq_back_due |=> found_back_mark_out)
        else $error("back edge not declared");

    AST_BACK_CLOSES: assert property (
        found_back_mark_out && !found_front_mark_out |-> !pulse_body_window_out)
        else $error("back mark did not close window");

    AST_BACK_LONG_CASE: assert property (
        pulse_body_window_out && !front_nxt && back_case_long
        |=> found_back_mark_out ##1 !found_back_mark_out || !pulse_body_window_out)
        else $error("long slope back edge missed");

    AST_FRONT_GATED: assert property (
        !gate_on |=> !found_front_mark_out)
        else $error("front mark while gate closed");

    AST_CLEAR_PULSES: assert property (
        seq_gate_open |=> buffer_clear_pulse_out && (&decoder_clear_out)
        ##1 !buffer_clear_pulse_out)
        else $error("clear pulses wrong on gate open");

    AST_BEAM_SELECT: assert property (
        inferred_front_flag_in
        |=> aligned_beam_flag_out == $past(beam_line_r[INFERRED_DELAY-1]))
        else $error("inferred beam path not selected");

    // Without the flag the selector must stay on the shorter real-mark tap
    AST_BEAM_REAL: assert property (
        !inferred_front_flag_in
        |=> aligned_beam_flag_out == $past(beam_line_r[REAL_DELAY-1]))
        else $error("real beam path not selected");

    AST_SIDELOBE: assert property (
        sum_h_r[edge_digitizer_pkg::AGE_NOW] && !beam_h_r[edge_digitizer_pkg::AGE_NOW]
        |=> sidelobe_pulse_out)
        else $error("sidelobe not flagged");

endmodule

//--- bench/quantizer_model.sv
// Behavioural video quantizer that plays per-clock patterns onto the pins.
// Assumes the digitizer samples pins on the rising edge; lines change 1 ns after it.
`timescale 1ns/1ps
module quantizer_model (
    // Clock
    input wire logic core_clk_in,
    // Two-level video toward the digitizer
    output logic sum_video_out,
    output logic rising_slope_out,
    output logic falling_slope_out,
    output logic mainbeam_flag_out
);
    initial begin
        {sum_video_out, rising_slope_out, falling_slope_out, mainbeam_flag_out} = 4'h0;
    end
    // Bit i of each pattern stands for clock i; all four lines return low after
    task automatic play(input logic [31:0] s, r, f, b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_in);
            #1;
            {sum_video_out, rising_slope_out, falling_slope_out, mainbeam_flag_out} =
                {s[i], r[i], f[i], b[i]};
        end
        @(posedge core_clk_in);
        #1;
        {sum_video_out, rising_slope_out, falling_slope_out, mainbeam_flag_out} = 4'h0;
    endtask
endmodule

//--- bench/reply_video_edge_digitizer_tb.sv
// Self-checking bench for the reply video edge digitizer.
// Assumes the quantizer model drives the video pins; the bench drives gate and flag.
`timescale 1ns/1ps
module reply_video_edge_digitizer_tb;
    localparam int RD = 3;
    localparam int ID = 8;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic range_gate_in = 1'b0;
    logic inferred_front_flag_in = 1'b0;
    logic sum_v, rise_s, fall_s, beam_f;
    logic front, back, window, sidelobe, buf_clr, aligned;
    logic [3:0] dec_clr;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int start, n_front, n_back, n_win, n_side, n_buf, n_dec, n_al, first_al;

    always #5 core_clk_in = ~core_clk_in;

    quantizer_model qm (.core_clk_in(core_clk_in), .sum_video_out(sum_v),
        .rising_slope_out(rise_s), .falling_slope_out(fall_s), .mainbeam_flag_out(beam_f));

    reply_video_edge_digitizer #(.REAL_DELAY(RD), .INFERRED_DELAY(ID)) DUT (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .sum_video_in(sum_v),
        .rising_slope_in(rise_s), .falling_slope_in(fall_s), .mainbeam_flag_in(beam_f),
        .range_gate_in(range_gate_in), .inferred_front_flag_in(inferred_front_flag_in),
        .found_front_mark_out(front), .found_back_mark_out(back),
        .pulse_body_window_out(window), .sidelobe_pulse_out(sidelobe),
        .decoder_clear_out(dec_clr), .buffer_clear_pulse_out(buf_clr),
        .aligned_beam_flag_out(aligned));

    // Unknowns never count, so a stuck-X output shows up as a missing pulse
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        n_front <= n_front + (front === 1'b1);
        n_back <= n_back + (back === 1'b1);
        n_win <= n_win + (window === 1'b1);
        n_side <= n_side + (sidelobe === 1'b1);
        n_buf <= n_buf + (buf_clr === 1'b1);
        n_dec <= n_dec + (dec_clr === 4'hF);
        n_al <= n_al + (aligned === 1'b1);
        if (aligned === 1'b1 && first_al < 0) first_al <= cyc - start;
    end

    task automatic check_int(input string what, input int exp, input int got);
        samples_checked++;
        if (exp !== got) begin
            n_fail++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (exp !== got) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic clear_counts();
        {n_front, n_back, n_win, n_side, n_buf, n_dec, n_al} = '0;
        first_al = -1;
        start = cyc;
    endtask

    // Plays one pulse and lets the pipeline drain before counts are read
    task automatic run_pulse(input logic [31:0] s, r, f, b);
        clear_counts();
        qm.play(s, r, f, b, 16);
        repeat (24) @(posedge core_clk_in);
        #1;
    endtask

    task automatic test_reset();
        check_bit("front", 1'b0, front);
        check_bit("window", 1'b0, window);
        check_bit("buffer_clear", 1'b0, buf_clr);
        check_bit("aligned", 1'b0, aligned);
        check_int("decoder_clear", 0, int'(dec_clr));
        $display("test_reset done");
    endtask

    task automatic test_init();
        clear_counts();
        range_gate_in = 1'b1;
        repeat (10) @(posedge core_clk_in);
        #1;
        check_int("buffer_clear pulses", 1, n_buf);
        check_int("decoder_clear pulses", 1, n_dec);
        $display("test_init done");
    endtask

    task automatic test_front();
        run_pulse(32'h3F, 32'h1, 32'h0, 32'h3F);
        check_int("front marks", 1, n_front);
        check_int("window cycles", 5, n_win);
        check_int("back marks", 1, n_back);
        $display("test_front done");
    endtask

    // Slope shapes for back-edge cases b, c, d, e; plain video-low would be later
    task automatic test_back_edges();
        logic [31:0] s [4] = '{32'h1F, 32'h3F, 32'hFFF, 32'h7F};
        logic [31:0] r [4] = '{32'h1, 32'h1, 32'h1, 32'h41};
        logic [31:0] f [4] = '{32'h10, 32'h30, 32'h70, 32'h30};
        for (int i = 0; i < 4; i++) begin
            run_pulse(s[i], r[i], f[i], 32'h0);
            check_int("case front marks", 1, n_front);
            check_int("case back marks", 1, n_back);
            check_int("case window cycles", 3, n_win);
        end
        $display("test_back_edges done");
    endtask

    task automatic test_gate_low();
        range_gate_in = 1'b0;
        run_pulse(32'h3F, 32'h1, 32'h10, 32'h3F);
        check_int("gated front marks", 0, n_front);
        check_int("gated back marks", 0, n_back);
        check_int("gated window cycles", 0, n_win);
        range_gate_in = 1'b1;
        repeat (8) @(posedge core_clk_in);
        // Step off the edge so the next clear is not overtaken by the counters
        #1;
        $display("test_gate_low done");
    endtask

    task automatic test_beam();
        int t_real;
        run_pulse(32'h3F, 32'h1, 32'h0, 32'h0);
        check_int("sidelobe without beam", 1, int'(n_side > 0));
        check_int("aligned without beam", 0, n_al);
        run_pulse(32'h3F, 32'h1, 32'h0, 32'h3F);
        check_int("sidelobe with beam", 0, n_side);
        t_real = first_al;
        inferred_front_flag_in = 1'b1;
        run_pulse(32'h3F, 32'h1, 32'h0, 32'h3F);
        inferred_front_flag_in = 1'b0;
        check_int("aligned seen", 1, int'(t_real >= 0));
        check_int("inferred path extra delay", ID - RD, first_al - t_real);
        $display("test_beam done");
    endtask

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clear_counts();
        repeat (2) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        test_reset();
        test_init();
        test_front();
        test_back_edges();
        test_gate_low();
        test_beam();
        summarize();
    end

    // Whole run is a few hundred clocks; this is well beyond it
    initial begin
        #100us;
        n_fail++;
        summarize();
    end
endmodule
